// ==== rtl/smi_pkg.sv ====
/*
 package for the serial mii phy block: segment layout, status bit
 positions, elasticity fifo sizing and timing constants.
 assumes a single system clock shared with the mac.
*/
package smi_pkg;
   // segment length in clocks and bit slots within a segment
   localparam int SEG_LEN      = 10;
   localparam int SLOT_CRS     = 0;
   localparam int SLOT_DV      = 1;
   localparam int SLOT_D0      = 2;
   localparam int SLOT_TX_ER   = 0;
   localparam int SLOT_TX_EN   = 1;
   // repeats of each segment at the slow rate
   localparam int SLOW_REPEAT  = 10;
   // inter-frame status bit positions
   localparam int ST_PREV_ERR  = 0;
   localparam int ST_SPEED     = 1;
   localparam int ST_DUPLEX    = 2;
   localparam int ST_LINK      = 3;
   localparam int ST_JABBER    = 4;
   localparam int ST_NIB_OK    = 5;
   localparam int ST_FALSE_CRS = 6;
   localparam int ST_ONE       = 7;
   // elasticity fifo: 9-bit entries (dv + byte), four entries give 36
   localparam int FIFO_WIDTH   = 9;
   localparam int FIFO_DEPTH   = 4;
   localparam int FIFO_HALF    = FIFO_DEPTH / 2;
   // reference clock
   localparam int CLK_MHZ      = 125;

   // one received byte with its valid flag
   typedef struct packed {
      logic       dv;
      logic [7:0] data;
   } smi_rx_word_t;

   // one decoded transmit segment
   typedef struct packed {
      logic       er;
      logic       en;
      logic [7:0] data;
   } smi_tx_seg_t;
endpackage

// ==== rtl/smi_efifo.sv ====
/*
 elasticity fifo for receive bytes. write side is the line-side byte
 strobe, read side is the segment slot. reports overflow and underflow.
 assumes both strobes are on the same clock, one pulse each.
*/
`timescale 1ns/1ps
`default_nettype none
module smi_efifo
   import smi_pkg::*;
#(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             flush_i,
   // write side
   input  wire logic             wr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   // read side
   input  wire logic             rd_i,
   output logic      [WIDTH-1:0] rdata_o,
   output logic                  half_o,
   output logic                  empty_o,
   output logic                  ovf_o,
   output logic                  unf_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic             full;
   logic             do_wr;
   logic             do_rd;

   assign full    = (cnt_q == (AW+1)'(DEPTH));
   assign empty_o = (cnt_q == '0);
   assign half_o  = (cnt_q >= (AW+1)'(DEPTH / 2));
   assign do_wr   = wr_i && (!full || rd_i);
   assign do_rd   = rd_i && !empty_o;
   assign ovf_o   = wr_i && full && !rd_i;
   assign unf_o   = rd_i && empty_o;

   always_ff @(posedge sys_clk_i) begin
      if (do_wr) begin
         mem_q[wp_q] <= wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || flush_i) begin
         wp_q    <= '0;
         rp_q    <= '0;
         cnt_q   <= '0;
         rdata_o <= '0;
      end else begin
         if (do_wr) begin
            wp_q <= AW'((wp_q + 1'b1) % DEPTH);
         end
         if (do_rd) begin
            rp_q    <= AW'((rp_q + 1'b1) % DEPTH);
            rdata_o <= mem_q[rp_q];
         end
         cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule // smi_efifo
`default_nettype wire

// ==== rtl/smi_phy.sv ====
/*
 phy side of a serial mii link: serialises receive segments onto the rx
 line and deserialises transmit segments from the tx line, framed by the
 mac's sync pulse. assumes sync, tx and line-side inputs share sys_clk_i;
 sync and tx come from the mac, so they pass two flip-flops first.
*/
`timescale 1ns/1ps
`default_nettype none
module smi_phy
   import smi_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   // serial link
   input  wire logic       sync_i,
   input  wire logic       tx_i,
   output logic            rx_o,
   // line-side receive
   input  wire logic       line_crs_i,
   input  wire logic       line_rx_wr_i,
   input  wire logic [7:0] line_rx_data_i,
   input  wire logic       line_rx_end_i,
   input  wire logic       line_rx_err_i,
   input  wire logic       line_nib_ok_i,
   input  wire logic       line_false_crs_i,
   // status
   input  wire logic       speed_100_i,
   input  wire logic       full_duplex_i,
   input  wire logic       link_up_i,
   input  wire logic       jabber_i,
   // line-side transmit
   output logic            tx_wr_o,
   output logic [7:0]      tx_data_o,
   output logic            tx_en_o,
   output logic            tx_er_o
);
   logic [1:0]   sync_s_q;
   logic [1:0]   tx_s_q;
   logic         seg_d_q;
   logic         pop_slot;
   logic         held_q;
   logic [3:0]   rep_q;
   logic         seg_start;
   logic         new_byte;
   logic [9:0]   rx_seg_q;
   logic [9:0]   tx_sh_q;
   logic         crs_q;
   logic         prev_err_q;
   logic         prev_nib_q;
   logic         false_crs_q;
   logic         frame_err_q;
   logic         in_frame_q;
   logic         started_q;
   logic         fifo_rd;
   logic         half;
   logic         empty;
   logic         ovf;
   logic         unf;
   logic [8:0]   rdata;
   smi_rx_word_t rword;
   smi_tx_seg_t  tseg;
   logic [7:0]   status;

   // sync and tx arrive from the mac
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sync_s_q <= '0;
         tx_s_q   <= '0;
      end else begin
         sync_s_q <= {sync_s_q[0], sync_i};
         tx_s_q   <= {tx_s_q[0], tx_i};
      end
   end

   // segment boundary; seg_d_q marks the clock right after it
   assign seg_start = sync_s_q[1];
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         seg_d_q <= 1'b0;
      end else begin
         seg_d_q <= seg_start;
      end
   end

   // repeat counter: a new byte every segment at 100, every tenth at 10
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rep_q <= '0;
      end else if (seg_start) begin
         rep_q <= (rep_q == 4'(SLOW_REPEAT - 1)) ? 4'h0 : rep_q + 4'h1;
      end
   end
   assign new_byte = seg_start && (speed_100_i || rep_q == 4'h0);

   // carrier sense bypasses the fifo and ignores transmit activity
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         crs_q <= 1'b0;
      end else begin
         crs_q <= line_crs_i;
      end
   end

   smi_efifo u_fifo (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .flush_i   (line_rx_end_i && !in_frame_q && empty),
      .wr_i      (line_rx_wr_i),
      .wdata_i   ({1'b1, line_rx_data_i}),
      .rd_i      (fifo_rd),
      .rdata_o   (rdata),
      .half_o    (half),
      .empty_o   (empty),
      .ovf_o     (ovf),
      .unf_o     (unf)
   );

   // pop one clock after a boundary whose next segment takes a new byte;
   // the fifo's registered output then stands for all copies of a group
   assign pop_slot = seg_d_q && (speed_100_i || rep_q == 4'h0);
   // drain starts only once half full; runs until emptied after frame end
   assign fifo_rd  = pop_slot && started_q && !(empty && !in_frame_q);
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         started_q <= 1'b0;
      end else if (!started_q && half) begin
         started_q <= 1'b1;
      end else if (started_q && empty && !in_frame_q && pop_slot) begin
         started_q <= 1'b0;
      end
   end

   // the popped word is still owed to the link until the next pop slot
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         held_q <= 1'b0;
      end else if (pop_slot) begin
         held_q <= fifo_rd && !empty;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         in_frame_q <= 1'b0;
      end else if (line_rx_wr_i) begin
         in_frame_q <= 1'b1;
      end else if (line_rx_end_i) begin
         in_frame_q <= 1'b0;
      end
   end

   // frame error collects line errors and fifo slips, set wins over clear
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         frame_err_q <= 1'b0;
      end else if (line_rx_err_i || ((ovf || (unf && in_frame_q)))) begin
         frame_err_q <= 1'b1;
      end else if (fifo_rd && !empty && !in_frame_q && !started_q) begin
         frame_err_q <= 1'b0;
      end else if (line_rx_wr_i && !in_frame_q) begin
         frame_err_q <= 1'b0;
      end
   end

   // previous-frame status latched at frame end, held until the next frame end
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         prev_err_q <= 1'b0;
         prev_nib_q <= 1'b0;
      end else if (line_rx_end_i) begin
         prev_err_q <= frame_err_q || line_rx_err_i || ovf;
         prev_nib_q <= line_nib_ok_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         false_crs_q <= 1'b0;
      end else if (line_false_crs_i) begin
         false_crs_q <= 1'b1;
      end else if (line_rx_wr_i) begin
         false_crs_q <= 1'b0;
      end
   end

   assign rword = smi_rx_word_t'(rdata);
   always_comb begin
      status               = '0;
      status[ST_PREV_ERR]  = prev_err_q;
      status[ST_SPEED]     = speed_100_i;
      status[ST_DUPLEX]    = full_duplex_i;
      status[ST_LINK]      = link_up_i;
      status[ST_JABBER]    = jabber_i;
      status[ST_NIB_OK]    = prev_nib_q;
      status[ST_FALSE_CRS] = false_crs_q;
      status[ST_ONE]       = 1'b1;
   end

   // segment is built at sync, then shifted out lsb first
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rx_seg_q <= '0;
      end else if (seg_start) begin
         rx_seg_q[SLOT_CRS] <= crs_q;
         if (held_q && rword.dv) begin
            rx_seg_q[SLOT_DV]         <= 1'b1;
            rx_seg_q[9:SLOT_D0]       <= rword.data;
         end else begin
            rx_seg_q[SLOT_DV]         <= 1'b0;
            rx_seg_q[9:SLOT_D0]       <= status;
         end
      end else begin
         rx_seg_q <= {1'b0, rx_seg_q[9:1]};
      end
   end
   assign rx_o = rx_seg_q[0];

   // transmit: shift in, capture whole segment at the next sync that takes a new byte
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         tx_sh_q <= '0;
      end else begin
         tx_sh_q <= {tx_s_q[1], tx_sh_q[9:1]};
      end
   end
   assign tseg = '{er: tx_sh_q[SLOT_TX_ER], en: tx_sh_q[SLOT_TX_EN],
                   data: tx_sh_q[9:SLOT_D0]};

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         tx_wr_o   <= 1'b0;
         tx_en_o   <= 1'b0;
         tx_er_o   <= 1'b0;
         tx_data_o <= '0;
      end else begin
         tx_wr_o <= new_byte;
         if (new_byte) begin
            tx_en_o   <= tseg.en;
            tx_er_o   <= tseg.er;
            // status from the mac is dropped here
            tx_data_o <= tseg.en ? tseg.data : 8'h00;
         end
      end
   end

   slot_period_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      seg_start |=> !seg_start[*8]) else $error("sync spacing");
   status_one_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      seg_start ##1 !rx_seg_q[SLOT_DV] |-> rx_seg_q[9]) else
      $error("status bit7 not one");
   crs_follow_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      seg_start ##1 1'b1 |-> rx_seg_q[SLOT_CRS] == $past(crs_q)) else
      $error("crs slot wrong");
   tx_ignore_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      tx_wr_o && !tx_en_o |-> tx_data_o == 8'h00) else
      $error("tx data leaked");
   fifo_start_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(started_q) |-> $past(half)) else $error("early drain");
   slip_err_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ovf |=> frame_err_q) else $error("overflow not flagged");
   prev_err_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      line_rx_end_i && frame_err_q |=> prev_err_q) else
      $error("prev error lost");
   false_crs_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      line_false_crs_i |=> false_crs_q) else $error("false crs lost");
endmodule // smi_phy
`default_nettype wire

// ==== verification/smi_mac_model.sv ====
/*
 mac side of the serial link: free running sync, tx segment serialiser
 and rx segment capture.
 assumes the phy puts the carrier bit of a segment on rx three clocks
 after the edge that saw sync, then one bit per clock.
*/
`timescale 1ns/1ps
`default_nettype none
module smi_mac_model
   import smi_pkg::*;
(
   // clock
   input  wire logic        sys_clk_i,
   // segment to send, held by the bench
   input  wire smi_tx_seg_t seg_i,
   // serial link
   input  wire logic        rx_i,
   output logic             sync_o,
   output logic             tx_o,
   // captured receive segment, bit 0 is carrier
   output logic [9:0]       rx_seg_o,
   output logic             rx_stb_o
);
   int         cnt  = 0;
   int         ph   = 0;
   bit         seen = 1'b0;
   logic [9:0] txs  = 10'h000;
   logic [9:0] sh   = 10'h000;

   initial begin
      sync_o = 1'b0;
      tx_o = 1'b0;
      rx_seg_o = 10'h000;
      rx_stb_o = 1'b0;
   end

   // segment latched on the rising edge before the sync slot, so a bench
   // change at a falling edge neither races it nor tears a segment
   always @(posedge sys_clk_i) begin
      if (cnt == 0) begin
         txs <= {seg_i.data, seg_i.en, seg_i.er};
      end
   end

   always @(negedge sys_clk_i) begin
      sync_o <= (cnt == 0);
      tx_o   <= txs[cnt];
      cnt = (cnt + 1) % SEG_LEN;
   end

   // the first window after start is partial, so it is never reported
   always @(posedge sys_clk_i) begin
      sh = {rx_i, sh[9:1]};
      ph = sync_o ? 0 : ph + 1;
      // the tenth bit of a segment arrives two clocks after the next sync
      rx_stb_o <= (ph == 2) && seen;
      if (ph == 2) begin
         rx_seg_o <= sh;
         seen = 1'b1;
      end
   end
endmodule // smi_mac_model
`default_nettype wire

// ==== verification/tb.sv ====
/*
 self-checking bench for the serial mii phy: status, frames, transmit.
 assumes smi_phy and the mac model; line side is driven at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import smi_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sync, tx, rx, tx_wr, tx_en, tx_er, rx_stb;
   logic [7:0]  tx_data;
   logic [9:0]  rx_seg;
   logic        crs = 1'b0, wr = 1'b0, fin = 1'b0, err = 1'b0;
   logic        nib = 1'b0, fcrs = 1'b0;
   logic [7:0]  rdata = 8'h00;
   logic [3:0]  st = 4'h0;  // jabber, link, duplex, speed
   smi_tx_seg_t seg;
   logic [3:0]  pat [4] = '{4'h5, 4'hA, 4'hF, 4'h0};
   smi_tx_seg_t tv [3] = '{'{1'b0, 1'b1, 8'h5A}, '{1'b1, 1'b1, 8'hC3},
                           '{1'b0, 1'b0, 8'hEE}};
   int          num_errors = 0, checks = 0, cyc = 0, k;
   logic [9:0]  s;

   smi_phy smi_phy_inst (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sync_i(sync), .tx_i(tx),
      .rx_o(rx), .line_crs_i(crs), .line_rx_wr_i(wr),
      .line_rx_data_i(rdata), .line_rx_end_i(fin), .line_rx_err_i(err),
      .line_nib_ok_i(nib), .line_false_crs_i(fcrs), .speed_100_i(st[0]),
      .full_duplex_i(st[1]), .link_up_i(st[2]), .jabber_i(st[3]),
      .tx_wr_o(tx_wr), .tx_data_o(tx_data), .tx_en_o(tx_en),
      .tx_er_o(tx_er));
   smi_mac_model smi_mac_model_inst (
      .sys_clk_i(sys_clk), .seg_i(seg), .rx_i(rx), .sync_o(sync),
      .tx_o(tx), .rx_seg_o(rx_seg), .rx_stb_o(rx_stb));

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         results();
      end
   end

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic get_seg(output logic [9:0] v);
      @(posedge sys_clk);
      while (rx_stb !== 1'b1) @(posedge sys_clk);
      v = rx_seg;
   endtask

   task automatic wait_wr();
      @(posedge sys_clk);
      while (tx_wr !== 1'b1) @(posedge sys_clk);
   endtask

   // a gap of 1 outruns the segment rate so the fifo must overflow
   task automatic send_frame(input int n, input int gap, input logic e);
      crs = 1'b1;
      nib = 1'b1;
      for (int i = 0; i < n; i++) begin
         repeat (gap) @(negedge sys_clk);
         rdata = 8'hA0 + 8'(i);
         wr = 1'b1;
         err = e;
         @(negedge sys_clk);
         wr = 1'b0;
      end
      crs = 1'b0;
      fin = 1'b1;
      @(negedge sys_clk);
      fin = 1'b0;
      err = 1'b0;
   endtask

   // returns the first status segment after the data
   task automatic collect(input int n, output logic [9:0] v);
      int c;
      c = 0;
      do get_seg(v); while (v[1] !== 1'b1);
      if (n > 0) check("crs in frame", 8'(v[0]), 8'h01);
      while (v[1] === 1'b1) begin
         if (n > 0) check("rx byte", v[9:2], 8'hA0 + 8'(c));
         c++;
         get_seg(v);
      end
      if (n > 0) check("byte count", 8'(c), 8'(n));
   endtask

   initial begin
      seg = '{er: 1'b0, en: 1'b0, data: 8'hEE};
      repeat (3) @(negedge sys_clk);
      rst_n = 1'b1;
      foreach (pat[i]) begin
         @(negedge sys_clk);
         st = pat[i];
         repeat (3) get_seg(s);
         check("status", s[9:2], {3'b100, pat[i], 1'b0});
         check("status dv", 8'(s[1]), 8'h00);
      end
      $display("test idle status done");
      @(negedge sys_clk);
      st = 4'h7;
      fcrs = 1'b1;
      @(negedge sys_clk);
      fcrs = 1'b0;
      repeat (3) get_seg(s);
      check("false carrier", 8'(s[8]), 8'h01);
      $display("test false carrier done");
      for (int f = 0; f < 3; f++) begin
         @(negedge sys_clk);
         fork
            send_frame(8, f == 2 ? 1 : 9, f == 1);
            collect(f == 2 ? 0 : 8, s);
         join
         check("end status", s[9:2], {3'b101, st, f != 0});
         check("end ctl", 8'(s[1:0]), 8'h00);
      end
      $display("test frames done");
      foreach (tv[i]) begin
         @(negedge sys_clk);
         seg = tv[i];
         // up to a segment to latch, one to send, one to capture
         repeat (3) wait_wr();
         check("tx en", 8'(tx_en), 8'(tv[i].en));
         check("tx er", 8'(tx_er), 8'(tv[i].er));
         check("tx data", tx_data, tv[i].en ? tv[i].data : 8'h00);
         get_seg(s);
         check("crs vs tx", 8'(s[0]), 8'h00);
      end
      $display("test transmit done");
      @(negedge sys_clk);
      st = 4'h6;
      seg = tv[0];
      repeat (120) @(negedge sys_clk);
      k = 0;
      repeat (200) begin
         @(posedge sys_clk);
         if (tx_wr === 1'b1) k++;
      end
      check("slow tx rate", 8'(k), 8'h02);
      $display("test slow rate done");
      results();
   end
endmodule // tb
`default_nettype wire
